// >>> pkg/sfrs_pkg.sv
// sfrs_pkg: constants shared by the switch fundamental reset sequencer
package sfrs_pkg;

  // register byte offsets
  localparam logic [11:0] OFS_SWITCH_CONTROL = 12'h000;
  localparam logic [11:0] OFS_SMBUS_STATUS   = 12'h004;
  localparam logic [11:0] OFS_BOOT_STATUS    = 12'h008;
  localparam logic [11:0] OFS_SEQ_STATUS     = 12'h00C;
  localparam logic [11:0] OFS_PHY_LINK_BASE  = 12'h100;

  // switch_control_reg fields
  localparam int BIT_REGISTER_UNLOCK = 0;
  localparam int BIT_RESET_HALT      = 1;
  // smbus_status_reg fields
  localparam int BIT_EEPROM_LOAD_DONE = 0;
  localparam int BIT_EEPROM_ERROR     = 1;
  localparam int POS_EEPROM_ERR_CODE  = 8;
  // phy_link_state_reg fields
  localparam int BIT_FULL_LINK_RETRAIN = 0;

  // reset values
  localparam logic [7:0]  RST_ERR_CODE = 8'h00;
  localparam logic [31:0] RST_TIMER    = 32'h0000_0000;

  // timing: times in ms, clock in kHz, counts derived
  localparam int unsigned CLK_KHZ    = 250000;
  localparam int unsigned T_STACK_MS = 20;
  localparam int unsigned T_READY_MS = 100;
  localparam logic [31:0] STACK_CYC  = 32'(T_STACK_MS * CLK_KHZ);
  localparam logic [31:0] READY_CYC  = 32'(T_READY_MS * CLK_KHZ);

  // port operating modes and partition states
  localparam logic [2:0] PM_DISABLED   = 3'h0;
  localparam logic [2:0] PM_DOWNSTREAM = 3'h1;
  localparam logic [2:0] PM_UPSTREAM   = 3'h2;
  localparam logic [2:0] PM_UNATTACHED = 3'h5;
  localparam logic [1:0] PS_DISABLED   = 2'h0;
  localparam logic [1:0] PS_ACTIVE     = 2'h1;

  // switch mode encodings
  localparam logic [3:0] SM_SINGLE    = 4'h0;
  localparam logic [3:0] SM_SINGLE_EE = 4'h1;
  localparam logic [3:0] SM_P0UP      = 4'h8;
  localparam logic [3:0] SM_P2UP      = 4'h9;
  localparam logic [3:0] SM_P0UP_EE   = 4'hA;
  localparam logic [3:0] SM_P2UP_EE   = 4'hB;
  localparam logic [3:0] SM_MULTI     = 4'hC;
  localparam logic [3:0] SM_MULTI_EE  = 4'hD;

  // sequencer states
  typedef enum logic [3:0] {
    ST_HOLD    = 4'h0,
    ST_REGINIT = 4'h1,
    ST_UNLOCK  = 4'h2,
    ST_PLL     = 4'h3,
    ST_MSMB    = 4'h4,
    ST_SSMB    = 4'h5,
    ST_STACK   = 4'h6,
    ST_EELOAD  = 4'h7,
    ST_HALTCHK = 4'h8,
    ST_QUASI   = 4'h9,
    ST_RELOCK  = 4'hA,
    ST_NORMAL  = 4'hB
  } sfrs_state_e;

endpackage : sfrs_pkg

// >>> verilog/sfrs_sync.sv
// sfrs_sync: two-stage synchroniser for pin levels
`timescale 1ns/100ps
`default_nettype none
module sfrs_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_nrst,
  // levels
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } sfrs_sync_s;

  sfrs_sync_s q_r;
  sfrs_sync_s q_nxt;

  // first stage feeds only the second
  always_comb begin
    q_nxt.meta = i_async;
    q_nxt.sync = q_r.meta;
  end

  // register both stages; pins read low after reset, so the sequence holds
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign o_sync = q_r.sync;

endmodule : sfrs_sync
`default_nettype wire

// >>> verilog/sfrs_mode_dec.sv
// sfrs_mode_dec: decodes the sampled switch mode into initial port and partition setup
`timescale 1ns/100ps
`default_nettype none
module sfrs_mode_dec #(
  parameter int NPORTS = 12,
  parameter int NPART  = 12
) (
  // sampled switch mode
  input  wire logic [3:0]          i_switch_mode,
  // decoded setup
  output logic                     o_eeprom_mode,
  output logic                     o_test_mode,
  output logic [NPORTS*3-1:0]      o_port_mode,
  output logic [NPART*2-1:0]       o_part_state
);
  import sfrs_pkg::*;

  // port 2 is addressed directly, so at least three ports are needed
  if (NPORTS < 3 || NPART < 1) begin
    $error("sfrs_mode_dec: unsupported parameter values");
  end

  // mode table; each mode and its EE counterpart differ only in eeprom loading
  always_comb begin
    o_eeprom_mode = 1'b0;
    o_test_mode   = 1'b0;
    o_part_state  = '0;
    o_port_mode   = '0;
    case (i_switch_mode)
      SM_SINGLE, SM_SINGLE_EE, SM_P0UP, SM_P0UP_EE, SM_P2UP, SM_P2UP_EE: begin
        o_part_state[1:0] = PS_ACTIVE;
        for (int p = 0; p < NPORTS; p++) begin
          o_port_mode[p*3 +: 3] = PM_DOWNSTREAM;
        end
        if (i_switch_mode == SM_P2UP || i_switch_mode == SM_P2UP_EE) begin
          o_port_mode[2:0] = PM_DISABLED;
          o_port_mode[8:6] = PM_UPSTREAM;
        end else begin
          o_port_mode[2:0] = PM_UPSTREAM;
          if (i_switch_mode == SM_P0UP || i_switch_mode == SM_P0UP_EE) begin
            o_port_mode[8:6] = PM_DISABLED;
          end
        end
      end
      SM_MULTI, SM_MULTI_EE: begin
        for (int p = 0; p < NPORTS; p++) begin
          o_port_mode[p*3 +: 3] = PM_UNATTACHED;
        end
      end
      default: begin
        o_test_mode = 1'b1;
      end
    endcase
    o_eeprom_mode = (i_switch_mode == SM_SINGLE_EE) || (i_switch_mode == SM_P0UP_EE) ||
                    (i_switch_mode == SM_P2UP_EE) || (i_switch_mode == SM_MULTI_EE);
  end

endmodule : sfrs_mode_dec
`default_nettype wire

// >>> verilog/sfrs_seq.sv
// sfrs_seq: switch fundamental reset sequencer with apb register slave
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module sfrs_seq #(
  parameter int          NPORTS    = 12,
  parameter int          NPART     = 12,
  parameter logic [31:0] STACK_CYC = sfrs_pkg::STACK_CYC,
  parameter logic [31:0] READY_CYC = sfrs_pkg::READY_CYC
) (
  // clock and reset
  input  wire logic                 i_clock,
  input  wire logic                 i_nrst,
  // apb slave
  input  wire logic                 i_psel,
  input  wire logic                 i_penable,
  input  wire logic                 i_pwrite,
  input  wire logic [11:0]          i_paddr,
  input  wire logic [31:0]          i_pwdata,
  output logic      [31:0]          o_prdata,
  output logic                      o_pready,
  output logic                      o_pslverr,
  // reset and strap pins
  input  wire logic                 i_global_reset_in_n,
  input  wire logic                 i_master_smbus_slow_select,
  input  wire logic [3:0]           i_eeprom_smbus_addr_straps,
  input  wire logic [3:0]           i_slave_smbus_addr_straps,
  input  wire logic [3:0]           i_switch_mode_straps,
  input  wire logic                 i_reset_halt_strap,
  // pll and serdes
  output logic                      o_pll_init,
  input  wire logic                 i_pll_lock,
  // master smbus
  output logic                      o_msmb_init,
  output logic                      o_msmb_slow,
  output logic      [3:0]           o_msmb_eeprom_addr,
  input  wire logic                 i_msmb_ready,
  // slave smbus
  output logic                      o_ssmb_rst_n,
  output logic      [3:0]           o_ssmb_addr,
  input  wire logic                 i_ssmb_ready,
  // eeprom loader
  output logic                      o_ee_load,
  input  wire logic                 i_ee_wr_valid,
  input  wire logic [11:0]          i_ee_wr_addr,
  input  wire logic [31:0]          i_ee_wr_data,
  input  wire logic                 i_ee_done,
  input  wire logic                 i_ee_err,
  input  wire logic [7:0]           i_ee_err_code,
  // stacks and links
  output logic                      o_stack_rst_n,
  output logic      [NPORTS-1:0]    o_link_retrain,
  output logic                      o_ports_ready,
  // tlp handling
  output logic                      o_cfg_retry,
  output logic                      o_type1_unsupported,
  output logic                      o_tlp_discard,
  output logic                      o_cfg_normal,
  // mode and status
  output logic                      o_register_unlock,
  output logic                      o_reset_halt,
  output logic      [NPORTS*3-1:0]  o_port_operating_mode,
  output logic      [NPART*2-1:0]   o_partition_state,
  output logic                      o_normal_op,
  output logic                      o_test_mode
);
  import sfrs_pkg::*;

  if (NPORTS < 3 || NPORTS > 16 || NPART < 1 || STACK_CYC == 0 || READY_CYC <= STACK_CYC) begin
    $error("sfrs_seq: unsupported parameter values");
  end

  typedef struct packed {
    sfrs_state_e          st;
    logic                 rst_d;
    logic                 tmr_on;
    logic [31:0]          timer;
    logic                 slow;
    logic [3:0]           ee_addr;
    logic [3:0]           ss_addr;
    logic [3:0]           switch_mode_straps;
    logic                 halt_strap;
    logic                 unlock;
    logic                 halt;
    logic                 ee_done;
    logic                 ee_err;
    logic [7:0]           ee_code;
    logic                 stack_rel;
    logic                 ready;
    logic [NPORTS-1:0]    retrain;
    logic [NPORTS*3-1:0]  port_mode;
    logic [NPART*2-1:0]   part_state;
    logic [31:0]          prdata;
    logic                 pslverr;
  } sfrs_seq_s;

  sfrs_seq_s q_r;
  sfrs_seq_s q_nxt;

  logic [14:0]         pins_s;
  logic                rst_s;
  logic                rst_rise;
  logic                ee_wv;
  logic                apb_wr;
  logic                wr_en;
  logic [11:0]         wr_addr;
  logic [31:0]         wr_data;
  logic                dec_ee;
  logic                dec_test;
  logic [NPORTS*3-1:0] dec_port;
  logic [NPART*2-1:0]  dec_part;

  // reset pin and straps cross into the clock domain together
  sfrs_sync #(
    .WIDTH (15)
  ) u_sync (
    .i_clock (i_clock),
    .i_nrst  (i_nrst),
    .i_async ({i_global_reset_in_n, i_master_smbus_slow_select, i_eeprom_smbus_addr_straps,
               i_slave_smbus_addr_straps, i_switch_mode_straps, i_reset_halt_strap}),
    .o_sync  (pins_s)
  );

  sfrs_mode_dec #(
    .NPORTS (NPORTS),
    .NPART  (NPART)
  ) u_dec (
    .i_switch_mode (q_r.switch_mode_straps),
    .o_eeprom_mode (dec_ee),
    .o_test_mode   (dec_test),
    .o_port_mode   (dec_port),
    .o_part_state  (dec_part)
  );

  // read decode: returns {error, data}
  function automatic logic [32:0] rd_word(input logic [11:0] a, input sfrs_seq_s s);
    logic [32:0] r;
    r = '0;
    if (a == OFS_SWITCH_CONTROL) begin
      r[BIT_REGISTER_UNLOCK] = s.unlock;
      r[BIT_RESET_HALT]      = s.halt;
    end else if (a == OFS_SMBUS_STATUS) begin
      r[BIT_EEPROM_LOAD_DONE]               = s.ee_done;
      r[BIT_EEPROM_ERROR]                   = s.ee_err;
      r[POS_EEPROM_ERR_CODE +: 8]           = s.ee_code;
    end else if (a == OFS_BOOT_STATUS) begin
      r[14:0] = {1'b0, s.slow, s.ee_addr, s.ss_addr, s.switch_mode_straps, s.halt_strap};
    end else if (a == OFS_SEQ_STATUS) begin
      r[3:0] = s.st;
      r[4]   = s.stack_rel;
      r[5]   = s.ready;
    end else if (a >= OFS_PHY_LINK_BASE && a < OFS_PHY_LINK_BASE + 12'(NPORTS * 4) &&
                 a[1:0] == 2'b00) begin
      r = '0; // retrain bit is self clearing
    end else begin
      r[32] = 1'b1;
    end
    return r;
  endfunction : rd_word

  // bus arbitration: loader writes win, apb access stalls for that cycle
  assign rst_s    = pins_s[14];
  assign rst_rise = rst_s & ~q_r.rst_d;
  assign ee_wv    = i_ee_wr_valid & (q_r.st == ST_EELOAD);
  assign o_pready = ~ee_wv;
  assign apb_wr   = i_psel & i_penable & i_pwrite & ~ee_wv;
  assign wr_en    = ee_wv | apb_wr;
  assign wr_addr  = ee_wv ? i_ee_wr_addr : i_paddr;
  assign wr_data  = ee_wv ? i_ee_wr_data : i_pwdata;

  // next-state logic for registers and sequence
  always_comb begin
    logic [32:0] rd;
    logic [11:0] pofs;
    rd          = rd_word(i_paddr, q_r);
    pofs        = wr_addr - OFS_PHY_LINK_BASE;
    q_nxt       = q_r;
    q_nxt.rst_d = rst_s;
    q_nxt.retrain = '0;
    // read data captured in the setup cycle
    if (i_psel && !i_penable) begin
      q_nxt.prdata  = rd[31:0];
      q_nxt.pslverr = rd[32];
    end
    // register writes take effect on the spot
    if (wr_en) begin
      if (wr_addr == OFS_SWITCH_CONTROL) begin
        q_nxt.halt = wr_data[BIT_RESET_HALT];
      end else if (wr_addr >= OFS_PHY_LINK_BASE && pofs < 12'(NPORTS * 4) &&
                   wr_addr[1:0] == 2'b00) begin
        q_nxt.retrain[pofs[5:2]] = wr_data[BIT_FULL_LINK_RETRAIN];
      end
    end
    // deadline timer from the release of global reset
    if (q_r.tmr_on) begin
      q_nxt.timer = q_r.timer + 32'h0000_0001;
      if (q_r.timer == STACK_CYC - 32'h0000_0001) begin
        q_nxt.stack_rel = 1'b1;
      end
      if (q_r.timer == READY_CYC - 32'h0000_0001) begin
        q_nxt.ready  = 1'b1;
        q_nxt.tmr_on = 1'b0;
      end
    end
    // sequence steps
    case (q_r.st)
      ST_HOLD: begin
        if (rst_rise) begin
          q_nxt.slow       = pins_s[13];
          q_nxt.ee_addr    = pins_s[12:9];
          q_nxt.ss_addr    = pins_s[8:5];
          q_nxt.switch_mode_straps     = pins_s[4:1];
          q_nxt.halt_strap = pins_s[0];
          q_nxt.tmr_on     = 1'b1;
          q_nxt.timer      = RST_TIMER;
          q_nxt.st         = ST_REGINIT;
        end
      end
      ST_REGINIT: begin
        q_nxt.unlock     = 1'b0;
        q_nxt.halt       = q_r.halt_strap;
        q_nxt.ee_done    = 1'b0;
        q_nxt.ee_err     = 1'b0;
        q_nxt.ee_code    = RST_ERR_CODE;
        q_nxt.port_mode  = '0;
        q_nxt.part_state = '0;
        q_nxt.st         = ST_UNLOCK;
      end
      ST_UNLOCK: begin
        q_nxt.unlock = 1'b1;
        q_nxt.st     = ST_PLL;
      end
      ST_PLL: begin
        if (i_pll_lock) begin
          q_nxt.st = ST_MSMB;
        end
      end
      ST_MSMB: begin
        if (i_msmb_ready) begin
          q_nxt.st = ST_SSMB;
        end
      end
      ST_SSMB: begin
        if (i_ssmb_ready) begin
          q_nxt.st = ST_STACK;
        end
      end
      ST_STACK: begin
        q_nxt.stack_rel = 1'b1;
        q_nxt.st        = dec_ee ? ST_EELOAD : ST_HALTCHK;
      end
      ST_EELOAD: begin
        if (i_ee_err) begin
          q_nxt.halt    = 1'b1;
          q_nxt.ee_err  = 1'b1;
          q_nxt.ee_code = i_ee_err_code;
          q_nxt.st      = ST_HALTCHK;
        end else if (i_ee_done) begin
          q_nxt.ee_done = 1'b1;
          q_nxt.st      = ST_HALTCHK;
        end
      end
      ST_HALTCHK: begin
        q_nxt.st = q_r.halt ? ST_QUASI : ST_RELOCK;
      end
      ST_QUASI: begin
        if (!q_r.halt) begin
          q_nxt.st = ST_RELOCK;
        end
      end
      ST_RELOCK: begin
        q_nxt.unlock     = 1'b0;
        q_nxt.port_mode  = dec_port;
        q_nxt.part_state = dec_part;
        q_nxt.st         = ST_NORMAL;
      end
      ST_NORMAL: begin
        q_nxt.st = ST_NORMAL;
      end
      default: begin
        q_nxt.st = ST_HOLD;
      end
    endcase
    // global reset low sends the sequence back to hold, stops the timer and clears stack release, ready and retrain, cold or warm alike
    if (!rst_s) begin
      q_nxt.st        = ST_HOLD;
      q_nxt.tmr_on    = 1'b0;
      q_nxt.stack_rel = 1'b0;
      q_nxt.ready     = 1'b0;
      q_nxt.retrain   = '0;
    end
  end

  // state register
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  // outputs from state
  assign o_prdata              = q_r.prdata;
  assign o_pslverr             = q_r.pslverr;
  assign o_pll_init            = q_r.st == ST_PLL;
  assign o_msmb_init           = q_r.st == ST_MSMB;
  assign o_msmb_slow           = q_r.slow;
  assign o_msmb_eeprom_addr    = q_r.ee_addr;
  assign o_ssmb_rst_n          = q_r.st > ST_MSMB;
  assign o_ssmb_addr           = q_r.ss_addr;
  assign o_ee_load             = q_r.st == ST_EELOAD;
  assign o_stack_rst_n         = q_r.stack_rel;
  assign o_link_retrain        = q_r.retrain;
  assign o_ports_ready         = q_r.ready;
  assign o_cfg_retry           = (q_r.st == ST_EELOAD) || (q_r.st == ST_QUASI);
  assign o_type1_unsupported   = q_r.st == ST_QUASI;
  assign o_tlp_discard         = q_r.st == ST_QUASI;
  assign o_cfg_normal          = q_r.st > ST_QUASI;
  assign o_register_unlock     = q_r.unlock;
  assign o_reset_halt          = q_r.halt;
  assign o_port_operating_mode = q_r.port_mode;
  assign o_partition_state     = q_r.part_state;
  assign o_normal_op           = q_r.st == ST_NORMAL;
  assign o_test_mode           = (q_r.st == ST_NORMAL) && dec_test;

  // checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  AST_HOLD_IN_RESET: assert property (!rst_s |=> q_r.st == ST_HOLD)
    else $error("sequence not held while global reset low");
  AST_STRAP_SAMPLE: assert property (rst_rise && q_r.st == ST_HOLD |=>
    q_r.switch_mode_straps == $past(pins_s[4:1]) && q_r.halt_strap == $past(pins_s[0]))
    else $error("straps not sampled at reset release");
  AST_STRAP_IGNORE: assert property (!rst_rise |=> $stable(q_r.switch_mode_straps) && $stable(q_r.ee_addr))
    else $error("straps changed outside reset release");
  AST_REGINIT: assert property (q_r.st == ST_REGINIT && rst_s |=>
    !q_r.ee_done && !q_r.ee_err && q_r.halt == q_r.halt_strap)
    else $error("registers not returned to defaults");
  AST_UNLOCK: assert property (q_r.st == ST_UNLOCK && rst_s |=> q_r.unlock ##1 q_r.unlock)
    else $error("register unlock not set early");
  AST_STACK_DEADLINE: assert property (q_r.tmr_on && q_r.timer == STACK_CYC |-> o_stack_rst_n)
    else $error("stack reset still asserted at deadline");
  AST_READY_DEADLINE: assert property (rst_s && q_r.tmr_on && q_r.timer == READY_CYC - 32'h0000_0001
    |=> o_ports_ready)
    else $error("ports not ready at deadline");
  AST_LOAD_RETRY: assert property (q_r.st == ST_EELOAD |-> o_cfg_retry && !o_cfg_normal)
    else $error("config request not retried during load");
  AST_LOAD_ERROR: assert property (q_r.st == ST_EELOAD && i_ee_err && rst_s |=>
    q_r.halt && q_r.ee_err && q_r.st == ST_HALTCHK ##1 q_r.st == ST_QUASI)
    else $error("load error did not halt");
  AST_LOAD_DONE: assert property (q_r.st == ST_EELOAD && i_ee_done && !i_ee_err && rst_s |=>
    q_r.ee_done)
    else $error("load done not flagged");
  AST_RETRAIN: assert property (ee_wv && i_ee_wr_addr == OFS_PHY_LINK_BASE &&
    i_ee_wr_data[BIT_FULL_LINK_RETRAIN] && rst_s |=> o_link_retrain[0] ##1 !o_link_retrain[0])
    else $error("retrain not triggered at write time");
  AST_QUASI: assert property (q_r.st == ST_QUASI |-> o_tlp_discard && o_type1_unsupported
    && !o_cfg_normal)
    else $error("quasi reset behaviour missing");
  AST_RELOCK: assert property (q_r.st == ST_RELOCK && rst_s |=> !q_r.unlock && o_normal_op
    && o_port_operating_mode == $past(dec_port))
    else $error("unlock not cleared before normal operation");

  COV_NORMAL: cover property (q_r.st == ST_RELOCK ##1 q_r.st == ST_NORMAL);
  COV_QUASI_EXIT: cover property (q_r.st == ST_QUASI ##1 q_r.st == ST_RELOCK);
  COV_LOAD_DONE: cover property (q_r.st == ST_EELOAD && i_ee_done);
  COV_LOAD_ERR: cover property (q_r.st == ST_EELOAD && i_ee_err);

endmodule : sfrs_seq
`default_nettype wire

// >>> verilog/_unused_placeholder_none.sv
// sfrs_none: intentionally empty file holder
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// >>> verif/sfrs_far.sv
// sfrs_far: far side model with pll, smbus ends and eeprom loader
`timescale 1ns/100ps
`default_nettype none
module sfrs_far (
  // clock, requests from the sequencer and fail select from the bench
  input  wire logic        i_clock,
  input  wire logic        i_pll_init,
  input  wire logic        i_msmb_init,
  input  wire logic        i_ssmb_rst_n,
  input  wire logic        i_ee_load,
  input  wire logic        i_fail,
  // answers
  output logic             o_pll_lock,
  output logic             o_msmb_ready,
  output logic             o_ssmb_ready,
  output logic             o_wr_valid,
  output logic      [11:0] o_wr_addr,
  output logic      [31:0] o_wr_data,
  output logic             o_done,
  output logic             o_err,
  output logic      [7:0]  o_code
);
  logic [7:0] cnt = 8'h00;
  initial {o_pll_lock, o_msmb_ready, o_ssmb_ready, o_wr_valid, o_done, o_err} = 6'h00;
  initial {o_wr_addr, o_wr_data, o_code} = 52'h0;
  // slow or prompt ready; loader writes a retrain at step 2, ends at step 6
  always @(posedge i_clock) begin
    cnt          <= i_ee_load ? cnt + 8'h01 : 8'h00;
    o_pll_lock   <= i_pll_init & ($urandom_range(3) == 0);
    o_msmb_ready <= i_msmb_init & ($urandom_range(3) == 0);
    o_ssmb_ready <= i_ssmb_rst_n & ($urandom_range(2) == 0);
    o_wr_valid   <= i_ee_load && cnt == 8'h02;
    o_wr_addr    <= (cnt == 8'h02) ? 12'h100 : ~o_wr_addr;
    o_wr_data    <= (cnt == 8'h02) ? 32'h1 : ~o_wr_data;
    o_done       <= i_ee_load && cnt == 8'h06 && !i_fail;
    o_err        <= i_ee_load && cnt == 8'h06 && i_fail;
    o_code       <= i_fail ? 8'h5A : ~o_code;
  end
endmodule : sfrs_far
`default_nettype wire

// >>> verif/tb.sv
// tb: self-checking bench for the fundamental reset sequencer
`timescale 1ns/100ps
`default_nettype none
module tb;
  import sfrs_pkg::*;
  localparam int STK = 200;
  localparam int RDY = 1000;
  logic i_clock, i_nrst, psel, penable, pwrite, pready, pslverr, pin, slow, hs, fail, saw_rt;
  logic pi, pl, mi, mr, sr, sy, el, wv, dn, er, mslow, stk, rdy, rty, t1u, unl, hlt, nop, tm;
  logic tdc, cfn;
  logic [11:0] paddr, wa, rt;
  logic [31:0] pwdata, prdata, wd, rd;
  logic [3:0]  ea, sa, sm, mea, ssa;
  logic [7:0]  code;
  logic [35:0] pm;
  logic [23:0] ps;
  int err_total = 0;
  int checks_done = 0;
  sfrs_seq #(.STACK_CYC(32'(STK)), .READY_CYC(32'(RDY))) uut (.i_clock(i_clock),
    .i_nrst(i_nrst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_global_reset_in_n(pin), .i_master_smbus_slow_select(slow),
    .i_eeprom_smbus_addr_straps(ea), .i_slave_smbus_addr_straps(sa),
    .i_switch_mode_straps(sm), .i_reset_halt_strap(hs), .o_pll_init(pi), .i_pll_lock(pl),
    .o_msmb_init(mi), .o_msmb_slow(mslow), .o_msmb_eeprom_addr(mea), .i_msmb_ready(mr),
    .o_ssmb_rst_n(sr), .o_ssmb_addr(ssa), .i_ssmb_ready(sy), .o_ee_load(el),
    .i_ee_wr_valid(wv), .i_ee_wr_addr(wa), .i_ee_wr_data(wd), .i_ee_done(dn), .i_ee_err(er),
    .i_ee_err_code(code), .o_stack_rst_n(stk), .o_link_retrain(rt), .o_ports_ready(rdy),
    .o_cfg_retry(rty), .o_type1_unsupported(t1u), .o_tlp_discard(tdc), .o_cfg_normal(cfn),
    .o_register_unlock(unl), .o_reset_halt(hlt), .o_port_operating_mode(pm),
    .o_partition_state(ps), .o_normal_op(nop), .o_test_mode(tm));
  sfrs_far far (.i_clock(i_clock), .i_pll_init(pi), .i_msmb_init(mi), .i_ssmb_rst_n(sr),
    .i_ee_load(el), .i_fail(fail), .o_pll_lock(pl), .o_msmb_ready(mr), .o_ssmb_ready(sy),
    .o_wr_valid(wv), .o_wr_addr(wa), .o_wr_data(wd), .o_done(dn), .o_err(er), .o_code(code));
  // clock and retrain pulse watch
  initial begin
    i_clock = 0;
    forever #2 i_clock = ~i_clock;
  end
  always @(posedge i_clock) if (rt[0] === 1'b1) saw_rt <= 1'b1;
  task automatic chk(input string n, input logic [35:0] s, input logic [35:0] e);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clock) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge i_clock) penable <= 1'b1;
    do @(posedge i_clock); while (pready !== 1'b1);
    rd = prdata;
    {psel, penable} <= 2'b00;
  endtask : apb
  function automatic logic [35:0] xmode(input logic [3:0] m);
    logic [35:0] r;
    r = {12{PM_DOWNSTREAM}};
    case (m)
      4'h0, 4'h1: r[2:0] = PM_UPSTREAM;
      4'h8, 4'hA: r[8:0] = {PM_DISABLED, PM_DOWNSTREAM, PM_UPSTREAM};
      4'h9, 4'hB: r[8:0] = {PM_UPSTREAM, PM_DOWNSTREAM, PM_DISABLED};
      4'hC, 4'hD: r = {12{PM_UNATTACHED}};
      default: r = '0;
    endcase
    return r;
  endfunction : xmode
  task automatic run(input logic [3:0] m, input logic h, input logic f);
    int n;
    int sn;
    logic [8:0] st;
    logic ee;
    ee = m inside {4'h1, 4'hA, 4'hB, 4'hD};
    st = 9'($urandom);
    {pin, sm, hs, fail, saw_rt} <= {1'b0, m, h, f, 1'b0};
    {slow, ea, sa} <= st;
    repeat (6) @(posedge i_clock);
    pin <= 1'b1;
    n = 0;
    sn = 0;
    while (rdy !== 1'b1 && n < 1200) begin
      @(posedge i_clock);
      n++;
      if (stk === 1'b1 && sn == 0) sn = n;
    end
    {sm, slow, ea, sa, hs} <= ~{m, st, h};
    chk("stack_release", 36'(sn > 0 && sn <= STK + 4), 36'h1);
    chk("ports_ready", 36'(n <= RDY + 4), 36'h1);
    n = 0;
    while (nop !== 1'b1 && t1u !== 1'b1 && n < 300) begin
      @(posedge i_clock);
      n++;
    end
    if (h | f) begin
      chk("quasi", {rty, t1u, tdc, cfn, unl, hlt}, 6'h3B);
      apb(1'b0, OFS_SMBUS_STATUS, 32'h0);
      chk("smbus_status", rd[15:0], f ? 16'h5A02 : {15'h0, ee});
      apb(1'b1, OFS_SWITCH_CONTROL, 32'h0);
    end
    // let the inverted straps pass the synchroniser before looking
    repeat (4) @(posedge i_clock);
    chk("straps", {mslow, mea, ssa}, st);
    chk("normal", {nop, cfn, tdc, unl, hlt, tm}, {5'b11000, xmode(m) == 0});
    chk("retrain", saw_rt, ee);
    chk("port_mode", pm, xmode(m));
    chk("part_state", ps, 24'(m inside {4'h0, 4'h1, 4'h8, 4'h9, 4'hA, 4'hB}));
    $display("test mode %h halt %b fail %b done", m, h, f);
  endtask : run
  task automatic conclude;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  logic [3:0] sfrs_modes [9] = '{4'h0, 4'h1, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'h3};
  // main sequence
  initial begin
    {i_nrst, psel, penable, pwrite, paddr, pwdata, pin, slow, ea, sa, sm, hs, fail} = '0;
    saw_rt = 1'b0;
    void'($urandom(81980));
    repeat (8) @(posedge i_clock);
    i_nrst <= 1'b1;
    apb(1'b0, 12'hFF0, 32'h0);
    chk("unmapped", pslverr, 1'b1);
    foreach (sfrs_modes[i]) run(sfrs_modes[i], 1'b0, 1'b0);
    run(4'h8, 1'b1, 1'b0);
    run(4'hD, 1'b0, 1'b1);
    run(4'($urandom_range(15)), 1'($urandom), 1'b0);
    conclude();
  end
  // watchdog
  initial begin
    repeat (40000) @(posedge i_clock);
    err_total++;
    conclude();
  end
endmodule : tb
`default_nettype wire
